/* rtl/pfs_open_wire.sv */
/*
 Cell open-wire check: periodic per-cell sink pulse and drop evaluation.
 Assumes drop comparator inputs are already synchronised to clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
module pfs_open_wire #(
	parameter int unsigned CELLS = 16,
	parameter int unsigned MEAS_CYC = pfs_pkg::MEAS_CYCLES
) (
	// Clock and control
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Slots between pulses, zero stops the check
	input wire logic [7:0] interval_i,
	// Drop comparators, sampled at pulse end
	input wire logic [CELLS-1:0] fault_drop_i,
	input wire logic [CELLS-1:0] pf_drop_i,
	// Results
	output logic [CELLS-1:0] sink_en_o,
	output logic [CELLS-1:0] cell_fault_o,
	output logic [CELLS-1:0] cell_pf_o,
	output logic pf_any_o
);
	localparam int unsigned CW = $clog2(MEAS_CYC);
	localparam logic [CW-1:0] CNT_LAST = CW'(MEAS_CYC - 1);
	pfs_pkg::pfs_ow_state_t state_ff, nxt_state;
	logic [CW-1:0] cnt_ff;
	logic [7:0] slot_ff;
	logic [CELLS-1:0] fault_ff, pf_ff, nxt_fault, nxt_pf;
	wire cnt_wrap = (cnt_ff == CNT_LAST);
	wire last_slot = cnt_wrap && (slot_ff >= interval_i - 8'h01);
	wire pulse_end = (state_ff == pfs_pkg::OW_PULSE) && cnt_wrap;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
		pfs_pkg::OW_IDLE: begin
			if (interval_i != 8'h00)
				nxt_state = pfs_pkg::OW_WAIT;
		end
		pfs_pkg::OW_WAIT: begin
			if (interval_i == 8'h00)
				nxt_state = pfs_pkg::OW_IDLE;
			else if (last_slot)
				nxt_state = pfs_pkg::OW_PULSE;
		end
		pfs_pkg::OW_PULSE: begin
			if (cnt_wrap)
				nxt_state = pfs_pkg::OW_WAIT;
		end
		default: nxt_state = pfs_pkg::OW_IDLE;
		endcase
	end

	// Drop on cell i flags cell i and the one above it
	genvar gi;
	generate
		for (gi = 0; gi < CELLS; gi++) begin : g_cell
			wire below_fault = (gi == 0) ? 1'b0 : fault_drop_i[(gi == 0) ? 0 : gi-1];
			wire below_pf = (gi == 0) ? 1'b0 : pf_drop_i[(gi == 0) ? 0 : gi-1];
			assign nxt_fault[gi] = pulse_end ? (fault_drop_i[gi] | below_fault) : fault_ff[gi];
			assign nxt_pf[gi] = pf_ff[gi] | (pulse_end & (pf_drop_i[gi] | below_pf));
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_ff <= pfs_pkg::OW_IDLE;
			cnt_ff <= '0;
			slot_ff <= pfs_pkg::OW_SLOT_RST;
			fault_ff <= '0;
			pf_ff <= '0;
		end else if (ce_i) begin
			state_ff <= nxt_state;
			cnt_ff <= (cnt_wrap || state_ff == pfs_pkg::OW_IDLE) ? '0 : cnt_ff + 1'b1;
			slot_ff <= (state_ff != pfs_pkg::OW_WAIT || last_slot) ? 8'h00 :
				(cnt_wrap ? slot_ff + 8'h01 : slot_ff);
			fault_ff <= nxt_fault;
			pf_ff <= nxt_pf;
		end
	end

	assign sink_en_o = {CELLS{state_ff == pfs_pkg::OW_PULSE}};
	assign cell_fault_o = fault_ff;
	assign cell_pf_o = pf_ff;
	assign pf_any_o = |pf_ff;

	property p_ow_start;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && state_ff == pfs_pkg::OW_WAIT && interval_i != 8'h00 && last_slot) |=> sink_en_o[0];
	endproperty
	a_ow_start: assert property (p_ow_start) else $error("open-wire pulse did not start");
	property p_ow_stop;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && pulse_end) |=> !sink_en_o[0];
	endproperty
	a_ow_stop: assert property (p_ow_stop) else $error("open-wire pulse too long");
	property p_ow_pair;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && pulse_end && fault_drop_i[0]) |=> (cell_fault_o[0] && cell_fault_o[1]);
	endproperty
	a_ow_pair: assert property (p_ow_pair) else $error("open-wire fault not on both cells");
	property p_ow_pf;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && pulse_end && pf_drop_i[0]) |=> (cell_pf_o[1] && pf_any_o);
	endproperty
	a_ow_pf: assert property (p_ow_pf) else $error("open-wire failure not raised");
endmodule
`default_nettype wire

/* rtl/pfs_pkg.sv */
/*
 Constants, types and carriers shared by the protection fault signalling logic.
 Assumes one 50 MHz system clock and a synchronous active-high reset.
*/
// Summary of operation
// - Alarm pin selects alarm, thermistor, analog, output, link.
// - Alarm drive style: active-high, active-low or open-drain.
// - Single-wire link function always drives open-drain.
// - Active-high level from internal or user regulator.
// - Alarm styles: low/hi-Z, high/low, low/high.
// - Programmable mask picks which sources raise alarm.
// - Fault pins: fault output, thermistor, analog, output.
// - Fault pin high level from chosen regulator.
// - Fault outputs mirror charge and discharge switch-off faults.
// - Fuse pin asserted on permanent failure when enabled.
// - Idle fuse pin is hi-Z and sensed.
// - Sensed high fuse pin raises permanent failure.
// - Fuse blown only above programmed voltage threshold, unless the check is bypassed.
// - Voltage check may use pack instead of stack.
// - Open-wire sink pulses once per interval, 3 ms.
// - Open wire faults cell and above, then fails.
package pfs_pkg;
	typedef enum logic [2:0] {
		FN_PRIMARY = 3'h0,
		FN_THERM = 3'h1,
		FN_ADCIN = 3'h2,
		FN_GPO = 3'h3,
		FN_LINK = 3'h4
	} pfs_func_t;
	typedef enum logic [1:0] {
		DRV_OPEN_DRAIN = 2'h0,
		DRV_ACT_HIGH = 2'h1,
		DRV_ACT_LOW = 2'h2
	} pfs_drive_t;
	typedef enum logic {
		SUP_INTERNAL_1V8_REGULATOR = 1'h0,
		SUP_USER_REGULATOR_ONE = 1'h1
	} pfs_supply_t;
	typedef enum logic [2:0] {
		OW_IDLE = 3'h1,
		OW_WAIT = 3'h2,
		OW_PULSE = 3'h4
	} pfs_ow_state_t;
	typedef struct packed {
		pfs_func_t func;
		pfs_drive_t drive;
		pfs_supply_t supply;
		logic gpo_level;
	} pfs_pin_cfg_t;
	typedef struct packed {
		logic out;
		logic oe;
		logic analog_en;
		pfs_supply_t supply;
	} pfs_pin_drv_t;
	localparam int unsigned CLK_FREQ_HZ = 50_000_000;
	localparam int unsigned MEAS_TIME_US = 3000;
	localparam int unsigned MEAS_CYCLES = MEAS_TIME_US * (CLK_FREQ_HZ / 1_000_000);
	localparam pfs_pin_drv_t PIN_DRV_RST = 4'h0;
	localparam logic PF_RST = 1'b0;
	localparam logic FUSE_RST = 1'b0;
	localparam logic [7:0] OW_SLOT_RST = 8'h00;
endpackage

/* rtl/pfs_top.sv */
/*
 Alarm, fault-indication and fuse pin logic with the open-wire check.
 Assumes analog comparators and pin inputs are asynchronous, and that
 the surrounding logic provides the flags, fault sources and link drive.
*/
`timescale 1ns/1ps
`default_nettype none
module pfs_top #(
	parameter int unsigned FLAGS = 16,
	parameter int unsigned CHG_SRC = 8,
	parameter int unsigned DSG_SRC = 8,
	parameter int unsigned CELLS = 16,
	parameter int unsigned MEAS_CYC = pfs_pkg::MEAS_CYCLES
) (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Pin configuration
	input wire pfs_pkg::pfs_pin_cfg_t alarm_cfg_i,
	input wire pfs_pkg::pfs_pin_cfg_t [1:0] fault_cfg_i,
	// Alarm sources
	input wire logic [FLAGS-1:0] alarm_mask_i,
	input wire logic [FLAGS-1:0] status_flags_i,
	input wire logic [FLAGS-1:0] status_events_i,
	input wire logic [FLAGS-1:0] event_clear_i,
	// Protection fault sources
	input wire logic [CHG_SRC-1:0] chg_fault_src_i,
	input wire logic [DSG_SRC-1:0] dsg_fault_src_i,
	input wire logic pf_src_i,
	// Fuse configuration
	input wire logic fuse_blow_en_i,
	input wire logic fuse_sense_pf_en_i,
	input wire logic fuse_check_pack_i,
	input wire logic fuse_check_bypass_i,
	// Open-wire configuration
	input wire logic [7:0] ow_interval_i,
	// Asynchronous comparators
	input wire logic stack_above_fuse_i,
	input wire logic pack_above_fuse_i,
	input wire logic [CELLS-1:0] cell_fault_drop_i,
	input wire logic [CELLS-1:0] cell_pf_drop_i,
	// Single-wire host link
	input wire logic link_tx_low_i,
	output logic link_rx_o,
	// Alarm pin
	input wire logic alarm_pin_i,
	output logic alarm_pin_o,
	output logic alarm_pin_oe_o,
	output logic alarm_analog_en_o,
	output logic alarm_supply_o,
	// Fault-indication pins: 0 charge, 1 discharge
	output logic [1:0] fault_pin_o,
	output logic [1:0] fault_pin_oe_o,
	output logic [1:0] fault_analog_en_o,
	output logic [1:0] fault_supply_o,
	// Fuse pin
	input wire logic fuse_pin_i,
	output logic fuse_pin_o,
	output logic fuse_pin_oe_o,
	// Status
	output logic alarm_active_o,
	output logic [FLAGS-1:0] event_pending_o,
	output logic charge_fault_out_o,
	output logic discharge_fault_out_o,
	output logic permanent_failure_o,
	output logic fuse_sense_pf_o,
	output logic [CELLS-1:0] ow_sink_en_o,
	output logic [CELLS-1:0] ow_cell_fault_o,
	output logic [CELLS-1:0] ow_cell_pf_o
);
	localparam int unsigned AW = 4 + 2 * CELLS;

	// Pin drive from function, style and logical level
	function automatic pfs_pkg::pfs_pin_drv_t pin_drive(
		input pfs_pkg::pfs_pin_cfg_t cfg,
		input logic prim,
		input logic link_ok,
		input logic link_low
	);
		pfs_pkg::pfs_pin_drv_t d;
		logic lvl;
		d = pfs_pkg::PIN_DRV_RST;
		d.supply = cfg.supply;
		lvl = (cfg.func == pfs_pkg::FN_GPO) ? cfg.gpo_level : prim;
		case (cfg.func)
		pfs_pkg::FN_PRIMARY, pfs_pkg::FN_GPO: begin
			case (cfg.drive)
			pfs_pkg::DRV_ACT_HIGH: begin
				d.out = lvl;
				d.oe = 1'b1;
			end
			pfs_pkg::DRV_ACT_LOW: begin
				d.out = ~lvl;
				d.oe = 1'b1;
			end
			// Undefined style falls back to open-drain, never fights a bus
			default: begin
				d.out = 1'b0;
				d.oe = lvl;
			end
			endcase
		end
		pfs_pkg::FN_THERM, pfs_pkg::FN_ADCIN: begin
			d.analog_en = 1'b1;
		end
		pfs_pkg::FN_LINK: begin
			// Link pin only ever pulls low
			d.out = 1'b0;
			d.oe = link_ok & link_low;
		end
		default: begin
			d.out = 1'b0;
		end
		endcase
		return d;
	endfunction

	// Two-stage synchroniser for all asynchronous inputs
	logic [AW-1:0] meta_ff, sync_ff;
	wire [AW-1:0] async_w = {fuse_pin_i, alarm_pin_i, stack_above_fuse_i,
		pack_above_fuse_i, cell_fault_drop_i, cell_pf_drop_i};
	wire fuse_sync = sync_ff[AW-1];
	wire alarm_sync = sync_ff[AW-2];
	wire stack_ok = sync_ff[AW-3];
	wire pack_ok = sync_ff[AW-4];
	wire [CELLS-1:0] fault_drop_sync = sync_ff[2*CELLS-1:CELLS];
	wire [CELLS-1:0] pf_drop_sync = sync_ff[CELLS-1:0];

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else if (ce_i) begin
			meta_ff <= async_w;
			sync_ff <= meta_ff;
		end
	end

	// Alarm source evaluation
	logic [FLAGS-1:0] ev_ff;
	logic alarm_ff;
	// Clear loses to a new event in the same cycle
	wire [FLAGS-1:0] nxt_ev = (ev_ff & ~event_clear_i) | status_events_i;
	wire [FLAGS-1:0] alarm_src = (status_flags_i | ev_ff) & alarm_mask_i;
	wire nxt_alarm = |alarm_src;

	// Protection fault mirrors
	logic chg_ff, dsg_ff;
	wire nxt_chg = |chg_fault_src_i;
	wire nxt_dsg = |dsg_fault_src_i;

	// Permanent failure and fuse
	logic pf_ff, fuse_ff, sense_pf_ff;
	logic ow_pf_any;
	wire fuse_sensed_hi = fuse_sync & ~fuse_ff;
	wire sense_pf = fuse_sense_pf_en_i & fuse_sensed_hi;
	wire nxt_pf = pf_ff | pf_src_i | ow_pf_any | sense_pf;
	wire v_ok = fuse_check_bypass_i | (fuse_check_pack_i ? pack_ok : stack_ok);
	wire nxt_fuse = fuse_ff | (pf_ff & fuse_blow_en_i & v_ok);

	// Pin drives
	pfs_pkg::pfs_pin_drv_t alarm_drv_ff;
	wire pfs_pkg::pfs_pin_drv_t nxt_alarm_drv = pin_drive(alarm_cfg_i, nxt_alarm,
		1'b1, link_tx_low_i);
	wire [1:0] fault_lvl = {nxt_dsg, nxt_chg};

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ev_ff <= '0;
			alarm_ff <= 1'b0;
			chg_ff <= 1'b0;
			dsg_ff <= 1'b0;
			alarm_drv_ff <= pfs_pkg::PIN_DRV_RST;
		end else if (ce_i) begin
			ev_ff <= nxt_ev;
			alarm_ff <= nxt_alarm;
			chg_ff <= nxt_chg;
			dsg_ff <= nxt_dsg;
			alarm_drv_ff <= nxt_alarm_drv;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pf_ff <= pfs_pkg::PF_RST;
			fuse_ff <= pfs_pkg::FUSE_RST;
			sense_pf_ff <= 1'b0;
		end else if (ce_i) begin
			pf_ff <= nxt_pf;
			fuse_ff <= nxt_fuse;
			sense_pf_ff <= sense_pf_ff | sense_pf;
		end
	end

	// One drive stage per fault-indication pin; no link function here
	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_fault_pin
			// Register local to each pin, so each variable has one writer
			pfs_pkg::pfs_pin_drv_t drv_ff;
			wire pfs_pkg::pfs_pin_drv_t nxt_drv = pin_drive(fault_cfg_i[gp],
				fault_lvl[gp], 1'b0, 1'b0);
			always_ff @(posedge clk_sys_i) begin
				if (rst_i)
					drv_ff <= pfs_pkg::PIN_DRV_RST;
				else if (ce_i)
					drv_ff <= nxt_drv;
			end
			assign fault_pin_o[gp] = drv_ff.out;
			assign fault_pin_oe_o[gp] = drv_ff.oe;
			assign fault_analog_en_o[gp] = drv_ff.analog_en;
			assign fault_supply_o[gp] = drv_ff.supply;
		end
	endgenerate

	pfs_open_wire #(
		.CELLS(CELLS),
		.MEAS_CYC(MEAS_CYC)
	) u_open_wire (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.interval_i(ow_interval_i),
		.fault_drop_i(fault_drop_sync),
		.pf_drop_i(pf_drop_sync),
		.sink_en_o(ow_sink_en_o),
		.cell_fault_o(ow_cell_fault_o),
		.cell_pf_o(ow_cell_pf_o),
		.pf_any_o(ow_pf_any)
	);

	assign alarm_pin_o = alarm_drv_ff.out;
	assign alarm_pin_oe_o = alarm_drv_ff.oe;
	assign alarm_analog_en_o = alarm_drv_ff.analog_en;
	assign alarm_supply_o = alarm_drv_ff.supply;
	assign link_rx_o = alarm_sync;
	// Fuse drives high once and stays; blowing is not undone
	assign fuse_pin_o = fuse_ff;
	assign fuse_pin_oe_o = fuse_ff;
	assign alarm_active_o = alarm_ff;
	assign event_pending_o = ev_ff;
	assign charge_fault_out_o = chg_ff;
	assign discharge_fault_out_o = dsg_ff;
	assign permanent_failure_o = pf_ff;
	assign fuse_sense_pf_o = sense_pf_ff;

	property p_link_od;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && alarm_cfg_i.func == pfs_pkg::FN_LINK) |=> !alarm_pin_o;
	endproperty
	a_link_od: assert property (p_link_od) else $error("link pin driven high");
	property p_link_follow;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && alarm_cfg_i.func == pfs_pkg::FN_LINK) |=>
			(alarm_pin_oe_o == $past(link_tx_low_i));
	endproperty
	a_link_follow: assert property (p_link_follow) else $error("link pin not following");
	property p_alarm_high;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && alarm_cfg_i.func == pfs_pkg::FN_PRIMARY &&
			alarm_cfg_i.drive == pfs_pkg::DRV_ACT_HIGH && nxt_alarm)
			|=> (alarm_pin_o && alarm_pin_oe_o);
	endproperty
	a_alarm_high: assert property (p_alarm_high) else $error("active-high alarm not driven");
	property p_alarm_od_idle;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && alarm_cfg_i.func == pfs_pkg::FN_PRIMARY &&
			alarm_cfg_i.drive == pfs_pkg::DRV_OPEN_DRAIN && !nxt_alarm)
			|=> !alarm_pin_oe_o;
	endproperty
	a_alarm_od_idle: assert property (p_alarm_od_idle) else $error("open-drain idle driven");
	property p_mask_event;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && (status_events_i & alarm_mask_i) != '0) |=> ##1 (!ce_i || alarm_active_o);
	endproperty
	a_mask_event: assert property (p_mask_event) else $error("unmasked event lost");
	property p_alarm_release;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && alarm_src == '0) |=> !alarm_active_o;
	endproperty
	a_alarm_release: assert property (p_alarm_release) else $error("alarm held with no source");
	property p_set_wins;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && (status_events_i & event_clear_i) != '0) |=>
			((event_pending_o & $past(status_events_i)) == $past(status_events_i));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
	property p_fault_mirror;
		@(posedge clk_sys_i) disable iff (rst_i)
		ce_i |=> (charge_fault_out_o == $past(nxt_chg) &&
			discharge_fault_out_o == $past(nxt_dsg));
	endproperty
	a_fault_mirror: assert property (p_fault_mirror) else $error("fault output mismatch");
	property p_fault_pin;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && fault_cfg_i[0].func == pfs_pkg::FN_PRIMARY &&
			fault_cfg_i[0].drive == pfs_pkg::DRV_ACT_HIGH) |=>
			(fault_pin_oe_o[0] && fault_pin_o[0] == charge_fault_out_o);
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("charge fault pin wrong");
	property p_fuse_gate;
		@(posedge clk_sys_i) disable iff (rst_i)
		$rose(fuse_pin_oe_o) |-> ($past(v_ok) && $past(permanent_failure_o) &&
			$past(fuse_blow_en_i));
	endproperty
	a_fuse_gate: assert property (p_fuse_gate) else $error("fuse blown without check");
	property p_fuse_fire;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && permanent_failure_o && fuse_blow_en_i && v_ok) |=> fuse_pin_oe_o;
	endproperty
	a_fuse_fire: assert property (p_fuse_fire) else $error("fuse not asserted");
	property p_fuse_pack;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && !fuse_pin_oe_o && fuse_check_pack_i && !pack_ok &&
			!fuse_check_bypass_i) |=> !fuse_pin_oe_o;
	endproperty
	a_fuse_pack: assert property (p_fuse_pack) else $error("pack check ignored");
	property p_fuse_sense;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && !fuse_pin_oe_o && fuse_sense_pf_en_i && fuse_sync) |=>
			(permanent_failure_o && fuse_sense_pf_o);
	endproperty
	a_fuse_sense: assert property (p_fuse_sense) else $error("fuse sense missed");
	property p_ow_pf_path;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && ow_pf_any) |=> permanent_failure_o;
	endproperty
	a_ow_pf_path: assert property (p_ow_pf_path) else $error("open-wire failure not latched");
endmodule
`default_nettype wire

/* verif/pfs_host_model.sv */
/*
 Far side of the pins: host pull-up on the alarm line, fuse gate pull-down
 with an external secondary protector, host taking fault pins as interrupts.
 Assumes each pin is split into out and oe, oe high while the device drives.
*/
`timescale 1ns/1ps
`default_nettype none
module pfs_host_model (
	// Clock
	input wire logic clk_sys_i,
	// Device pins
	input wire logic alarm_pin_o,
	input wire logic alarm_pin_oe_o,
	input wire logic fuse_pin_o,
	input wire logic fuse_pin_oe_o,
	input wire logic [1:0] fault_pin_o,
	// Secondary protector request
	input wire logic protector_fire_i,
	// Resolved wires and host view
	output logic alarm_wire_o,
	output logic fuse_wire_o,
	output var int irq_cnt_o
);
	logic [1:0] fault_q = 2'h0;
	int irq_q = 0;
	assign irq_cnt_o = irq_q;
	// Pull-up keeps a released alarm line high
	assign alarm_wire_o = alarm_pin_oe_o ? alarm_pin_o : 1'h1;
	// Gate pull-down, so a released pin reads low unless the protector fires
	assign fuse_wire_o = (fuse_pin_oe_o & fuse_pin_o) | protector_fire_i;
	always @(posedge clk_sys_i) begin
		fault_q <= fault_pin_o;
		irq_q <= irq_q + $countones(fault_pin_o & ~fault_q);
	end
endmodule
`default_nettype wire

/* verif/protection_fault_signal_outputs_test.sv */
/*
 Self-checking bench for the pin signalling logic and open-wire check.
 Assumes pfs_host_model on the pin side and a short measurement time.
*/
`timescale 1ns/1ps
`default_nettype none
module protection_fault_signal_outputs_test;
	logic clk_sys_i = 1'h0;
	logic rst_i = 1'h1;
	pfs_pkg::pfs_pin_cfg_t acfg = '0;
	pfs_pkg::pfs_pin_cfg_t [1:0] fcfg = '0;
	logic [15:0] mask = '0, flags = '0, evts = '0, eclr = '0, fdrop = '0, pdrop = '0;
	logic [7:0] csrc = '0, dsrc = '0, ow_int = '0;
	logic pf_src = 1'h0, blow_en = 1'h0, sense_en = 1'h0, chk_pack = 1'h0;
	logic stk = 1'h0, pck = 1'h0, fire = 1'h0, link_low = 1'h0;
	logic byp = 1'h0, ce = 1'h1;
	wire logic a_wire, f_wire, a_o, a_oe, a_an, a_sup, fu_o, fu_oe, act, cfo, dfo, pf, spf, lrx;
	wire logic [1:0] fp_o, fp_oe, fp_an, fp_sup;
	wire logic [15:0] pend, sink, owf, owp;
	int irqs;
	int error_cnt = 0;
	int checks_done = 0;

	initial begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	// Short measurement slot keeps the open-wire run brief
	pfs_top #(.MEAS_CYC(8)) dut_u (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
		.alarm_cfg_i(acfg), .fault_cfg_i(fcfg),
		.alarm_mask_i(mask), .status_flags_i(flags), .status_events_i(evts),
		.event_clear_i(eclr), .chg_fault_src_i(csrc), .dsg_fault_src_i(dsrc),
		.pf_src_i(pf_src), .fuse_blow_en_i(blow_en), .fuse_sense_pf_en_i(sense_en),
		.fuse_check_pack_i(chk_pack), .fuse_check_bypass_i(byp), .ow_interval_i(ow_int),
		.stack_above_fuse_i(stk), .pack_above_fuse_i(pck), .cell_fault_drop_i(fdrop),
		.cell_pf_drop_i(pdrop), .link_tx_low_i(link_low), .link_rx_o(lrx),
		.alarm_pin_i(a_wire), .alarm_pin_o(a_o), .alarm_pin_oe_o(a_oe),
		.alarm_analog_en_o(a_an), .alarm_supply_o(a_sup), .fault_pin_o(fp_o),
		.fault_pin_oe_o(fp_oe), .fault_analog_en_o(fp_an), .fault_supply_o(fp_sup),
		.fuse_pin_i(f_wire), .fuse_pin_o(fu_o), .fuse_pin_oe_o(fu_oe),
		.alarm_active_o(act), .event_pending_o(pend), .charge_fault_out_o(cfo),
		.discharge_fault_out_o(dfo), .permanent_failure_o(pf), .fuse_sense_pf_o(spf),
		.ow_sink_en_o(sink), .ow_cell_fault_o(owf), .ow_cell_pf_o(owp)
	);

	pfs_host_model host_u (
		.clk_sys_i(clk_sys_i), .alarm_pin_o(a_o), .alarm_pin_oe_o(a_oe),
		.fuse_pin_o(fu_o), .fuse_pin_oe_o(fu_oe), .fault_pin_o(fp_o),
		.protector_fire_i(fire), .alarm_wire_o(a_wire), .fuse_wire_o(f_wire),
		.irq_cnt_o(irqs)
	);

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic at_edge();
		@(posedge clk_sys_i);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	function automatic pfs_pkg::pfs_pin_cfg_t cfg(input logic [2:0] f, input logic [1:0] d,
		input logic s, input logic g);
		return pfs_pkg::pfs_pin_cfg_t'({f, d, s, g});
	endfunction

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Sticky fuse and failure state only leave through reset
	task automatic do_reset();
		at_edge();
		rst_i <= 1'h1;
		pf_src <= 1'h0;
		blow_en <= 1'h0;
		sense_en <= 1'h0;
		chk_pack <= 1'h0;
		stk <= 1'h0;
		pck <= 1'h0;
		fire <= 1'h0;
		byp <= 1'h0;
		tick(5);
		at_edge();
		rst_i <= 1'h0;
		tick(1);
	endtask

	task automatic t_reset();
		chk("reset pins", 16'h0, {a_oe, a_an, fp_oe, fu_oe, pf, act});
		chk("reset sink", 16'h0, sink);
		$display("reset test done");
	endtask

	task automatic t_fault();
		at_edge();
		fcfg <= {cfg(3'h0, 2'h1, 1'h0, 1'h0), cfg(3'h0, 2'h1, 1'h0, 1'h0)};
		csrc <= 8'h20;
		tick(2);
		chk("charge fault", 16'h1, {dfo, cfo});
		chk("fault pins", 16'h1, fp_o);
		at_edge();
		csrc <= 8'h00;
		dsrc <= 8'h01;
		tick(2);
		chk("discharge fault", 16'h2, {dfo, cfo});
		chk("host irqs", 16'h2, irqs[15:0]);
		at_edge();
		dsrc <= 8'h00;
		fcfg <= {cfg(3'h1, 2'h0, 1'h0, 1'h0), cfg(3'h3, 2'h1, 1'h1, 1'h1)};
		tick(2);
		chk("fault gpo", 16'h3, {fp_oe[0], fp_o[0]});
		chk("fault supply", 16'h1, fp_sup[0]);
		chk("fault analog", 16'h4, {fp_an, fp_oe[1]});
		$display("fault test done");
	endtask

	task automatic t_alarm();
		for (int i = 0; i < 3; i++) begin
			at_edge();
			acfg <= cfg(3'h0, i[1:0], 1'h0, 1'h0);
			mask <= 16'h0008;
			flags <= 16'h0010;
			tick(2);
			chk("masked flag", 16'h0, act);
			chk("idle wire", (i == 1) ? 16'h0 : 16'h1, a_wire);
			chk("idle oe", (i != 0) ? 16'h1 : 16'h0, a_oe);
			at_edge();
			flags <= 16'h0018;
			tick(1);
			chk("alarm on", 16'h1, act);
			chk("active wire", (i == 1) ? 16'h1 : 16'h0, a_wire);
			at_edge();
			flags <= 16'h0010;
			tick(1);
			chk("alarm off", 16'h0, act);
		end
		$display("alarm test done");
	endtask

	// Event meeting its own clear in one cycle must survive
	task automatic t_event();
		at_edge();
		mask <= 16'h0004;
		evts <= 16'h0004;
		at_edge();
		evts <= 16'h0000;
		tick(2);
		chk("pending", 16'h0004, pend);
		chk("event alarm", 16'h1, act);
		at_edge();
		evts <= 16'h0004;
		eclr <= 16'h0004;
		at_edge();
		evts <= 16'h0000;
		eclr <= 16'h0000;
		tick(1);
		chk("set wins", 16'h0004, pend);
		// Clear seen with the enable low must not take effect
		at_edge();
		ce <= 1'h0;
		eclr <= 16'h0004;
		at_edge();
		ce <= 1'h1;
		eclr <= 16'h0000;
		tick(1);
		chk("frozen pending", 16'h0004, pend);
		at_edge();
		eclr <= 16'h0004;
		at_edge();
		eclr <= 16'h0000;
		tick(1);
		chk("cleared", 16'h0, pend);
		chk("alarm cleared", 16'h0, act);
		$display("event test done");
	endtask

	task automatic t_func();
		at_edge();
		acfg <= cfg(3'h3, 2'h1, 1'h1, 1'h1);
		tick(2);
		chk("gpo wire", 16'h1, a_wire);
		chk("gpo supply", 16'h1, a_sup);
		for (int i = 1; i < 3; i++) begin
			at_edge();
			acfg <= cfg(i[2:0], 2'h1, 1'h0, 1'h0);
			tick(2);
			chk("analog use", 16'h1, {a_oe, a_an});
		end
		at_edge();
		acfg <= cfg(3'h4, 2'h1, 1'h1, 1'h1);
		tick(2);
		chk("link idle", 16'h1, {a_oe, a_wire});
		chk("link rx idle", 16'h1, lrx);
		at_edge();
		link_low <= 1'h1;
		tick(4);
		chk("link low", 16'h2, {a_oe, a_wire});
		chk("link rx", 16'h0, lrx);
		at_edge();
		link_low <= 1'h0;
		$display("function test done");
	endtask

	task automatic t_fuse();
		at_edge();
		blow_en <= 1'h1;
		pf_src <= 1'h1;
		tick(4);
		chk("pf low stack", 16'h1, {fu_oe, pf});
		at_edge();
		stk <= 1'h1;
		tick(4);
		chk("fuse blow", 16'h3, {fu_oe, fu_o});
		do_reset();
		at_edge();
		blow_en <= 1'h1;
		chk_pack <= 1'h1;
		stk <= 1'h1;
		pf_src <= 1'h1;
		tick(4);
		chk("pack low", 16'h0, fu_oe);
		at_edge();
		pck <= 1'h1;
		tick(4);
		chk("pack high", 16'h1, fu_oe);
		do_reset();
		at_edge();
		sense_en <= 1'h1;
		fire <= 1'h1;
		tick(4);
		chk("idle fuse oe", 16'h0, fu_oe);
		chk("sensed pf", 16'h3, {pf, spf});
		do_reset();
		// Bypassed voltage check blows with the stack low
		at_edge();
		blow_en <= 1'h1;
		pf_src <= 1'h1;
		byp <= 1'h1;
		tick(4);
		chk("bypass blow", 16'h1, fu_oe);
		do_reset();
		$display("fuse test done");
	endtask

	task automatic t_ow();
		int n;
		n = 0;
		at_edge();
		fdrop <= 16'h0005;
		pdrop <= 16'h0001;
		blow_en <= 1'h1;
		stk <= 1'h1;
		ow_int <= 8'h01;
		for (int i = 0; i < 100 && sink !== 16'hffff; i++) tick(1);
		if (sink !== 16'hffff) begin
			error_cnt++;
			$display("Error sink pulse expected ffff seen %h", sink);
			wrap_up();
		end
		while (sink === 16'hffff && n < 50) begin
			n++;
			tick(1);
		end
		chk("pulse cycles", 16'h8, n[15:0]);
		at_edge();
		ow_int <= 8'h00;
		tick(3);
		chk("cell faults", 16'h000f, owf);
		chk("cell pf", 16'h0003, owp);
		chk("ow fuse", 16'h3, {pf, fu_oe});
		$display("open-wire test done");
	endtask

	initial begin
		do_reset();
		t_reset();
		t_fault();
		t_alarm();
		t_event();
		t_func();
		t_fuse();
		t_ow();
		wrap_up();
	end
endmodule
`default_nettype wire
